// ===== hdl/phy_diag_pkg.sv
/*
 * Constants for the diagnostic register bank: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 50 MHz pclk and APB with 32-bit data.
 */
package phy_diag_pkg;
    localparam int unsigned ADDR_W = 12;
    // Printed offsets are not all multiples of four: byte address = 4 * index
    localparam logic [9:0] IDX_INT_STATUS_THREE = 10'h018;
    localparam logic [9:0] IDX_SELFTEST_ONE     = 10'h01B;
    localparam logic [9:0] IDX_SELFTEST_TWO     = 10'h01C;
    localparam logic [9:0] IDX_CABLE_REFLECT    = 10'h01E;
    localparam logic [9:0] IDX_RESET_CONTROL    = 10'h01F;
    localparam logic [9:0] IDX_IRQ_STATUS       = 10'h040;
    localparam logic [9:0] IDX_IRQ_MASK         = 10'h041;
    localparam logic [9:0] IDX_DIAG_CONFIG      = 10'h042;

    // interrupt_status_three fields
    localparam int unsigned POR_PEND_BIT   = 12;
    localparam int unsigned NOFR_PEND_BIT  = 11;
    localparam int unsigned THIRD_PEND_BIT = 8;
    localparam int unsigned POR_EN_BIT     = 4;
    localparam int unsigned NOFR_EN_BIT    = 3;
    localparam int unsigned THIRD_EN_BIT   = 0;
    localparam logic [2:0]  EVT_EN_RESET   = 3'h4;   // {por, nofr, third}

    // Self-test fields
    localparam int unsigned ERR_LOCK_BIT  = 15;
    localparam logic [7:0]  IPG_RESET     = 8'h7D;
    localparam logic [10:0] PKT_LEN_RESET = 11'h5EE;
    localparam logic [7:0]  ERR_MAX       = 8'hFF;
    localparam logic [2:0]  IPG_UNIT      = 3'h4;

    // Reflectometry and reset control fields
    localparam int unsigned REFL_START_BIT = 15;
    localparam int unsigned REFL_DONE_BIT  = 1;
    localparam int unsigned REFL_FAIL_BIT  = 0;
    localparam int unsigned HW_RESET_BIT   = 15;
    localparam int unsigned SW_RESET_BIT   = 14;
    localparam int unsigned STANDBY_BIT    = 7;

    // Block interrupt status/mask bits and the diag config counter mode bit
    localparam int unsigned IRQ_N         = 4;
    localparam int unsigned IRQ_POR       = 0;
    localparam int unsigned IRQ_NOFR      = 1;
    localparam int unsigned IRQ_THIRD     = 2;
    localparam int unsigned IRQ_REFL_DONE = 3;
    localparam int unsigned ERR_MODE_BIT  = 0;

    // Reset pulse length driven to the transceiver core
    localparam int unsigned RESET_PULSE_NS   = 200;
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned RESET_PULSE_CYC  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_CNT_W      = 4;

    typedef enum logic [1:0] {
        REFL_IDLE = 2'b00,
        REFL_RUN  = 2'b01,
        REFL_END  = 2'b11
    } refl_state_t;
endpackage

// ===== hdl/diag_event_if.sv
/*
 * Carrier between the register bank and its event latch: raw event
 * levels in, pending flags out, read-clear strobe in.
 * Assumes all signals are on pclk.
 */
`timescale 1ns/1ps
interface diag_event_if;
    logic [2:0] raw;
    logic [2:0] pending;
    logic       read_clear;
    modport bank  (output raw, output read_clear, input pending);
    modport latch (input raw, input read_clear, output pending);
endinterface

// ===== hdl/event_latch.sv
/*
 * Latched-high pending flags for the three transceiver events.
 * Assumes event levels are already synchronised to pclk.
 */
`timescale 1ns/1ps
module event_latch (
    // Clock and reset
    input wire logic   pclk,
    input wire logic   presetn,
    // Events
    diag_event_if.latch ev
);
    import phy_diag_pkg::*;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_flag
            logic pend_q;
            // Event held through the read keeps the flag set
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend_q <= 1'b0;
                end else if (ev.raw[i]) begin
                    pend_q <= 1'b1;
                end else if (ev.read_clear) begin
                    pend_q <= 1'b0;
                end
            end
            assign ev.pending[i] = pend_q;
        end
    endgenerate
endmodule

// ===== hdl/selftest_counter.sv
/*
 * Errored-byte counter of the self-test checker with lock-and-clear.
 * Assumes err_byte is a one-cycle pulse on pclk from the checker.
 */
`timescale 1ns/1ps
module selftest_counter (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Checker side
    input  wire logic       err_byte,
    input  wire logic       wrap_mode,
    // Register side
    input  wire logic       lock_clear,
    output logic      [7:0] locked_count
);
    import phy_diag_pkg::*;

    logic [7:0] run_q;
    logic [7:0] lock_q;

    // A byte error in the lock cycle counts towards the next interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 8'h00;
        end else if (lock_clear) begin
            run_q <= {7'h00, err_byte};
        end else if (err_byte && (wrap_mode || run_q != ERR_MAX)) begin
            run_q <= run_q + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 8'h00;
        end else if (lock_clear) begin
            lock_q <= run_q;
        end
    end

    assign locked_count = lock_q;
endmodule

// ===== hdl/phy_diag_register_bank.sv
/*
 * Diagnostic management registers of a single-pair Ethernet transceiver:
 * interrupt status three, self-test control, cable reflectometry and
 * reset control, reached as an APB slave.
 * Assumes event, checker and measurement inputs come from pclk logic
 * except the event levels, which are synchronised here.
 */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module phy_diag_register_bank (
    // APB
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [phy_diag_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Event sources (asynchronous levels)
    input  wire logic                        por_done_evt,
    input  wire logic                        no_frame_evt,
    input  wire logic                        third_source_event,
    // Self-test checker and generator
    input  wire logic                        err_byte,
    output logic      [9:0]                  gap_bytes,
    output logic      [10:0]                 packet_bytes,
    // Reflectometry engine
    output logic                             refl_start,
    input  wire logic                        refl_done,
    input  wire logic                        refl_fail,
    // Transceiver control
    output logic                             core_reset,
    output logic                             core_restart,
    output logic                             standby,
    // Interrupts
    output logic                             phy_int,
    output logic                             irq
);
    import phy_diag_pkg::*;

    diag_event_if ev ();

    logic [2:0]       evt_s1_q;
    logic [2:0]       evt_s2_q;
    logic [2:0]       evt_en_q;
    logic [7:0]       ipg_q;
    logic [10:0]      pkt_len_q;
    logic             err_mode_q;
    logic             refl_done_q;
    logic             refl_fail_q;
    refl_state_t      refl_state_q;
    logic             standby_q;
    logic             hw_rst_q;
    logic             sw_rst_q;
    logic [RESET_CNT_W-1:0] rst_cnt_q;
    logic [IRQ_N-1:0] irq_stat_q;
    logic [IRQ_N-1:0] irq_mask_q;
    logic [31:0]      prdata_q;
    logic [2:0]       pend_prev_q;
    logic [7:0]       locked_count;

    logic             access;
    logic             wr;
    logic             rd;
    logic [9:0]       idx;
    logic             mapped;
    logic             lo_lane;
    logic             hi_lane;
    logic [15:0]      rdata16;
    logic [IRQ_N-1:0] irq_evt;

    assign access  = psel && penable;
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign idx     = paddr[ADDR_W-1:2];
    assign lo_lane = pstrb[0];
    assign hi_lane = pstrb[1];
    assign pready  = 1'b1;

    always_comb begin
        case (idx)
            IDX_INT_STATUS_THREE, IDX_SELFTEST_ONE, IDX_SELFTEST_TWO,
            IDX_CABLE_REFLECT, IDX_RESET_CONTROL,
            IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_DIAG_CONFIG: mapped = 1'b1;
            default:                                       mapped = 1'b0;
        endcase
    end

    // Unaligned or unmapped accesses error out and change nothing
    assign pslverr = access && (!mapped || paddr[1:0] != 2'b00);

    // Event level synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_s1_q <= 3'h0;
            evt_s2_q <= 3'h0;
        end else begin
            evt_s1_q <= {por_done_evt, no_frame_evt, third_source_event};
            evt_s2_q <= evt_s1_q;
        end
    end

    assign ev.raw        = evt_s2_q;
    assign ev.read_clear = rd && !pslverr && idx == IDX_INT_STATUS_THREE;

    event_latch u_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .ev      (ev)
    );

    selftest_counter u_counter (
        .pclk         (pclk),
        .presetn      (presetn),
        .err_byte     (err_byte),
        .wrap_mode    (err_mode_q),
        .lock_clear   (wr && !pslverr && idx == IDX_SELFTEST_ONE && hi_lane && pwdata[ERR_LOCK_BIT]),
        .locked_count (locked_count)
    );

    // Interrupt enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_en_q <= EVT_EN_RESET;
        end else if (wr && !pslverr && idx == IDX_INT_STATUS_THREE && lo_lane) begin
            evt_en_q <= {pwdata[POR_EN_BIT], pwdata[NOFR_EN_BIT], pwdata[THIRD_EN_BIT]};
        end
    end

    // Transceiver interrupt pin: pending flags gated by their enables
    assign phy_int = |(ev.pending & evt_en_q);

    // Self-test generator settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ipg_q <= IPG_RESET;
        end else if (wr && !pslverr && idx == IDX_SELFTEST_ONE && lo_lane) begin
            ipg_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_len_q <= PKT_LEN_RESET;
        end else if (wr && !pslverr && idx == IDX_SELFTEST_TWO) begin
            if (lo_lane) begin
                pkt_len_q[7:0] <= pwdata[7:0];
            end
            if (hi_lane) begin
                pkt_len_q[10:8] <= pwdata[10:8];
            end
        end
    end

    assign gap_bytes    = {ipg_q, 2'b00};
    assign packet_bytes = pkt_len_q;

    // Counter mode lives here because its home register is outside this bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_mode_q <= 1'b0;
        end else if (wr && !pslverr && idx == IDX_DIAG_CONFIG && lo_lane) begin
            err_mode_q <= pwdata[ERR_MODE_BIT];
        end
    end

    // Reflectometry: start runs until the engine reports done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refl_state_q <= REFL_IDLE;
        end else begin
            case (refl_state_q)
                REFL_IDLE: begin
                    if (wr && !pslverr && idx == IDX_CABLE_REFLECT && hi_lane && pwdata[REFL_START_BIT]) begin
                        refl_state_q <= REFL_RUN;
                    end
                end
                REFL_RUN: begin
                    if (refl_done) begin
                        refl_state_q <= REFL_END;
                    end
                end
                REFL_END: refl_state_q <= REFL_IDLE;
                default:  refl_state_q <= REFL_IDLE;
            endcase
        end
    end

    assign refl_start = refl_state_q == REFL_RUN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refl_done_q <= 1'b0;
            refl_fail_q <= 1'b0;
        end else if (refl_state_q == REFL_IDLE && wr && !pslverr && idx == IDX_CABLE_REFLECT
                     && hi_lane && pwdata[REFL_START_BIT]) begin
            refl_done_q <= 1'b0;
            refl_fail_q <= 1'b0;
        end else if (refl_state_q == REFL_RUN && refl_done) begin
            refl_done_q <= 1'b1;
            refl_fail_q <= refl_fail;
        end
    end

    // Reset control: both reset bits self-clear after a fixed pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_rst_q  <= 1'b0;
            sw_rst_q  <= 1'b0;
            rst_cnt_q <= '0;
        end else if (hw_rst_q || sw_rst_q) begin
            if (rst_cnt_q == RESET_CNT_W'(RESET_PULSE_CYC - 1)) begin
                hw_rst_q  <= 1'b0;
                sw_rst_q  <= 1'b0;
                rst_cnt_q <= '0;
            end else begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end
        end else if (wr && !pslverr && idx == IDX_RESET_CONTROL && hi_lane) begin
            hw_rst_q <= pwdata[HW_RESET_BIT];
            sw_rst_q <= pwdata[SW_RESET_BIT];
        end
    end

    // Standby is cleared by the full reset, kept by the restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_q <= 1'b0;
        end else if (hw_rst_q) begin
            standby_q <= 1'b0;
        end else if (wr && !pslverr && idx == IDX_RESET_CONTROL && lo_lane) begin
            standby_q <= pwdata[STANDBY_BIT];
        end
    end

    // The transceiver core sees the same reset as from its reset pin
    assign core_reset   = hw_rst_q;
    assign core_restart = sw_rst_q;
    assign standby      = standby_q;

    // Block interrupts: rising pending flags and measurement completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_prev_q <= 3'h0;
        end else begin
            pend_prev_q <= ev.pending;
        end
    end

    assign irq_evt[IRQ_POR]       = ev.pending[2] && !pend_prev_q[2];
    assign irq_evt[IRQ_NOFR]      = ev.pending[1] && !pend_prev_q[1];
    assign irq_evt[IRQ_THIRD]     = ev.pending[0] && !pend_prev_q[0];
    assign irq_evt[IRQ_REFL_DONE] = refl_state_q == REFL_RUN && refl_done;

    // New event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else if (wr && !pslverr && idx == IDX_IRQ_STATUS && lo_lane) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_N-1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= '0;
        end else if (wr && !pslverr && idx == IDX_IRQ_MASK && lo_lane) begin
            irq_mask_q <= pwdata[IRQ_N-1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Read mux
    always_comb begin
        rdata16 = 16'h0000;
        case (idx)
            IDX_INT_STATUS_THREE: begin
                rdata16[POR_PEND_BIT]   = ev.pending[2];
                rdata16[NOFR_PEND_BIT]  = ev.pending[1];
                rdata16[THIRD_PEND_BIT] = ev.pending[0];
                rdata16[POR_EN_BIT]     = evt_en_q[2];
                rdata16[NOFR_EN_BIT]    = evt_en_q[1];
                rdata16[THIRD_EN_BIT]   = evt_en_q[0];
            end
            IDX_SELFTEST_ONE:  rdata16 = {locked_count, ipg_q};
            IDX_SELFTEST_TWO:  rdata16 = {5'h00, pkt_len_q};
            IDX_CABLE_REFLECT: begin
                rdata16[REFL_START_BIT] = refl_state_q != REFL_IDLE;
                rdata16[REFL_DONE_BIT]  = refl_done_q;
                rdata16[REFL_FAIL_BIT]  = refl_fail_q;
            end
            IDX_RESET_CONTROL: begin
                rdata16[HW_RESET_BIT] = hw_rst_q;
                rdata16[SW_RESET_BIT] = sw_rst_q;
                rdata16[STANDBY_BIT]  = standby_q;
            end
            IDX_IRQ_STATUS:  rdata16 = {12'h000, irq_stat_q};
            IDX_IRQ_MASK:    rdata16 = {12'h000, irq_mask_q};
            IDX_DIAG_CONFIG: rdata16 = {15'h0000, err_mode_q};
            default:         rdata16 = 16'h0000;
        endcase
    end

    // Read data registered in the setup cycle so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= {16'h0000, rdata16};
        end
    end

    assign prdata = prdata_q;
endmodule

// ===== verification/phy_diag_checker.sv
/* Port assertions for the diagnostic register bank.
   Assumes it is bound to phy_diag_register_bank, one pclk domain. */
`timescale 1ns/1ps
module phy_diag_checker (
    // Clock, reset and APB
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [phy_diag_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                      pwdata,
    input wire logic [3:0]                       pstrb,
    // Watched outputs, and refl_done from the reflectometry engine
    input wire logic [9:0]                       gap_bytes,
    input wire logic [10:0]                      packet_bytes,
    input wire logic                             refl_start,
    input wire logic                             refl_done,
    input wire logic                             core_reset,
    input wire logic                             core_restart,
    input wire logic                             standby,
    input wire logic                             phy_int
);
    import phy_diag_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc_wr = psel && penable && pwrite;
    wire wr_st1 = acc_wr && paddr == {IDX_SELFTEST_ONE, 2'b00} && pstrb[0];
    wire wr_st2 = acc_wr && paddr == {IDX_SELFTEST_TWO, 2'b00} && pstrb[1:0] == 2'b11;
    wire wr_is3 = acc_wr && paddr == {IDX_INT_STATUS_THREE, 2'b00} && pstrb[0];
    // A write to the reset bits is ignored while either pulse is running
    wire wr_rc = acc_wr && paddr == {IDX_RESET_CONTROL, 2'b00} && !core_reset && !core_restart;
    property p_gap; wr_st1 |=> gap_bytes == {$past(pwdata[7:0]), 2'b00}; endproperty
    a_gap: assert property (p_gap) else $error("gap_bytes not four times gap field");
    property p_len; wr_st2 |=> packet_bytes == $past(pwdata[10:0]); endproperty
    a_len: assert property (p_len) else $error("packet_bytes not written value");
    property p_en_off; wr_is3 && (pwdata[4:0] & 5'h19) == 5'h00 |=> !phy_int; endproperty
    a_en_off: assert property (p_en_off) else $error("phy_int with enables cleared");
    property p_refl_end; refl_start && refl_done |=> !refl_start; endproperty
    a_refl_end: assert property (p_refl_end) else $error("start did not self-clear on done");
    property p_rst_go; wr_rc && pstrb[1] && pwdata[15] |=> core_reset; endproperty
    a_rst_go: assert property (p_rst_go) else $error("core_reset missing after write");
    property p_rst_len; $rose(core_reset) |-> core_reset[*8] ##1 core_reset[*2] ##1 !core_reset; endproperty
    a_rst_len: assert property (p_rst_len) else $error("core_reset pulse not ten cycles");
    property p_rsr_len; $rose(core_restart) |-> core_restart[*8] ##1 core_restart[*2] ##1 !core_restart; endproperty
    a_rsr_len: assert property (p_rsr_len) else $error("core_restart pulse not ten cycles");
    property p_stby; wr_rc && pstrb[0] && !pwdata[15] |=> standby == $past(pwdata[7]); endproperty
    a_stby: assert property (p_stby) else $error("standby differs from written bit");
    c_refl: cover property (refl_start && refl_done);
    c_rst: cover property ($rose(core_reset));
    c_int: cover property ($rose(phy_int));
endmodule

bind phy_diag_register_bank phy_diag_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .gap_bytes, .packet_bytes, .refl_start, .refl_done, .core_reset, .core_restart,
    .standby, .phy_int);

// ===== verification/phy_diag_register_bank_bench.sv
/* Self-checking bench for the diagnostic register bank.
   Assumes only APB from the bank; the master waits for pready. Reads are noted in a queue. */
`timescale 1ns/1ps
module phy_diag_register_bank_bench;
    import phy_diag_pkg::*;
    localparam logic [11:0] A_IS3 = {IDX_INT_STATUS_THREE, 2'b00};
    localparam logic [11:0] A_ST1 = {IDX_SELFTEST_ONE, 2'b00};
    localparam logic [11:0] A_ST2 = {IDX_SELFTEST_TWO, 2'b00};
    localparam logic [11:0] A_REF = {IDX_CABLE_REFLECT, 2'b00};
    localparam logic [11:0] A_RC  = {IDX_RESET_CONTROL, 2'b00};
    localparam logic [11:0] A_IST = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_IMK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_CFG = {IDX_DIAG_CONFIG, 2'b00};
    typedef struct {logic [31:0] v; logic [31:0] m; logic e;} note_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        err_byte = 0, refl_done = 0, refl_fail = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0]  pstrb = 0;
    logic [2:0]  evt = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, refl_start, core_reset, core_restart, standby, phy_int, irq;
    logic [9:0]  gap_bytes;
    logic [10:0] packet_bytes;
    logic [7:0]  v8;
    logic [10:0] v11;
    int          errors = 0, comparisons = 0, seed = 68, rst_hi = 0, rsr_hi = 0, k, n;
    int          pb[3] = '{POR_PEND_BIT, NOFR_PEND_BIT, THIRD_PEND_BIT};
    note_t       notes[$];

    phy_diag_register_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_done_evt(evt[0]), .no_frame_evt(evt[1]), .third_source_event(evt[2]),
        .err_byte(err_byte), .gap_bytes(gap_bytes), .packet_bytes(packet_bytes), .refl_start(refl_start),
        .refl_done(refl_done), .refl_fail(refl_fail), .core_reset(core_reset), .core_restart(core_restart),
        .standby(standby), .phy_int(phy_int), .irq(irq));

    initial begin
        forever #10 pclk = ~pclk;
    end

    task conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Waits end on a falling edge, where outputs have settled; drives wait for a rising edge
    task cyc(input int c);
        repeat (c) @(negedge pclk);
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'h3;
        @(posedge pclk);
        penable <= 1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) begin
            cmp("pready", 1, 0);
            conclude();
        end
        psel    <= 0;
        penable <= 0;
        @(negedge pclk);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input logic e);
        notes.push_back('{v, m, e});
        apb(0, a, 32'h0);
    endtask

    task errs(input int c);
        @(posedge pclk);
        repeat (c) begin
            err_byte <= 1;
            @(posedge pclk);
        end
        err_byte <= 0;
        cyc(1);
        apb(1, A_ST1, 32'h807D);
    endtask

    always @(posedge pclk) begin
        note_t x;
        rst_hi += (core_reset === 1'b1);
        rsr_hi += (core_restart === 1'b1);
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (notes.size() == 0)
                cmp("unnoted read", 1, 0);
            else begin
                x = notes.pop_front();
                cmp("prdata", x.v, prdata & x.m);
                cmp("pslverr", x.e, pslverr);
            end
        end
    end

    initial begin
        #1000000;
        cmp("watchdog", 0, 1);
        conclude();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        cyc(1);
        cmp("gap_bytes", 32'h1F4, gap_bytes);
        cmp("packet_bytes", 32'h5EE, packet_bytes);
        rd(A_IS3, 32'h0010, 32'hFFFF, 0);
        rd(A_ST1, 32'h007D, 32'hFFFF, 0);
        rd(A_ST2, 32'h05EE, 32'hFFFF, 0);
        rd(A_REF, 32'h0, 32'hFFFF, 0);
        rd(A_RC, 32'h0, 32'hFFFF, 0);
        rd(12'h200, 0, 0, 1);
        rd(12'h061, 0, 0, 1);
        $display("reset values done");
        apb(1, A_IS3, 32'hF919);
        rd(A_IS3, 32'h0019, 32'hFFFF, 0);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            evt[i] <= 1;
            cyc(5);
            cmp("phy_int", 1, phy_int);
            rd(A_IS3, (32'h1 << pb[i]) | 32'h19, 32'hFFFF, 0);
            apb(1, A_IS3, 32'h0);
            cmp("phy_int", 0, phy_int);
            apb(1, A_IS3, 32'h19);
            @(posedge pclk);
            evt[i] <= 0;
            cyc(4);
            rd(A_IS3, (32'h1 << pb[i]) | 32'h19, 32'hFFFF, 0);
            rd(A_IS3, 32'h19, 32'hFFFF, 0);
            cmp("phy_int", 0, phy_int);
            apb(1, A_IMK, 32'hF);
            cmp("irq", 1, irq);
            apb(1, A_IMK, 32'h0);
            cmp("irq", 0, irq);
            apb(1, A_IST, 32'h1 << i);
            rd(A_IST, 32'h0, 32'h7, 0);
        end
        $display("events done");
        n = 1 + ($unsigned($random(seed)) % 20);
        errs(n);
        rd(A_ST1, {16'h0, n[7:0], 8'h7D}, 32'hFFFF, 0);
        errs(300);
        rd(A_ST1, 32'hFF7D, 32'hFFFF, 0);
        apb(1, A_CFG, 32'h1);
        errs(260);
        rd(A_ST1, 32'h047D, 32'hFFFF, 0);
        apb(1, A_CFG, 32'h0);
        $display("error counter done");
        for (int j = 0; j < 3; j++) begin
            v8 = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'($random(seed));
            v11 = (j == 0) ? 11'h000 : (j == 1) ? 11'h7FF : 11'($random(seed));
            apb(1, A_ST1, {24'h0, v8});
            cmp("gap_bytes", {v8, 2'b00}, gap_bytes);
            rd(A_ST1, {24'h0, v8}, 32'h00FF, 0);
            apb(1, A_ST2, {16'h0, 5'h1F, v11});
            cmp("packet_bytes", v11, packet_bytes);
            rd(A_ST2, {21'h0, v11}, 32'hFFFF, 0);
        end
        $display("generator fields done");
        for (int f = 0; f < 2; f++) begin
            apb(1, A_REF, 32'h8000);
            cmp("refl_start", 1, refl_start);
            rd(A_REF, 32'h8000, 32'hFFFF, 0);
            @(posedge pclk);
            refl_done <= 1;
            refl_fail <= f[0];
            @(posedge pclk);
            refl_done <= 0;
            refl_fail <= 0;
            cyc(3);
            cmp("refl_start", 0, refl_start);
            rd(A_REF, 32'h2 | f, 32'hFFFF, 0);
        end
        $display("reflectometry done");
        apb(1, A_RC, 32'h0080);
        cmp("standby", 1, standby);
        k = rsr_hi;
        apb(1, A_RC, 32'h4080);
        cyc(20);
        cmp("core_restart cycles", 10, rsr_hi - k);
        cmp("standby", 1, standby);
        rd(A_RC, 32'h0080, 32'hFFFF, 0);
        k = rst_hi;
        apb(1, A_RC, 32'h8080);
        cyc(20);
        cmp("core_reset cycles", 10, rst_hi - k);
        cmp("standby", 0, standby);
        rd(A_RC, 32'h0, 32'hFFFF, 0);
        $display("reset control done");
        cyc(2);
        cmp("pending notes", 0, notes.size());
        conclude();
    end
endmodule
